//--- design/csmc_top.sv
`timescale 1ns/10ps
`default_nettype none
module csmc_top
  import csmc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [17:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ins_valid,
  input  wire csmc_pkg::csmc_ins_t  ins,
  output logic                      ins_ready,
  input  wire logic                 irq_req,
  input  wire logic [15:0]          irq_vec,
  output logic                      irq_ack,
  output logic      [7:0]           flags,
  output logic      [15:0]          pc,
  output logic      [15:0]          sp,
  output logic                      store_valid,
  output logic      [7:0]           store_data,
  output csmc_pkg::csmc_mv_t        mv,
  output csmc_pkg::csmc_bus_t       bus,
  input  wire logic [15:0]          bus_rdata,
  input  wire logic                 hw_standby_pin_n,
  input  wire logic                 mode_pin_high,
  input  wire logic                 mode_pin_low,
  output csmc_pkg::csmc_pwr_t       pwr,
  output logic      [1:0]           mode,
  output logic                      mode_expanded,
  output logic                      rom_enable,
  output logic                      ports_gpio
);
  import csmc_pkg::*;

  csmc_state_t state_r;          // cpu state
  logic [7:0]  ccr_r;            // condition_flags_register
  logic [15:0] pc_r;             // program counter
  logic [15:0] sp_r;             // stack pointer
  logic [15:0] vec_r;            // vector address of taken interrupt
  logic [7:0]  mv_byte_r;        // byte in flight during block move
  csmc_mv_t    mv_r;             // block move count and pointers
  logic        st_valid_r;       // store flags strobe
  logic [7:0]  st_data_r;        // stored flags byte
  logic        irq_ack_r;        // interrupt taken strobe
  logic [7:0]  sysctl_r;         // system_control
  logic [1:0]  mds_r;            // mode status bits
  logic [1:0]  mode_r;           // latched operating mode
  logic        mode_ok_r;        // mode latched since reset release
  logic [31:0] prdata_r;         // apb read data
  logic        err_r;            // apb unmapped flag
  csmc_pwr_t   pwr_r;            // power-down outputs
  logic        hs1, hs2;         // standby pin synchroniser
  logic [1:0]  md1, md2;         // mode pin synchroniser
  logic        go_r;             // start one access
  logic        issued_r;         // access outstanding for this state
  csmc_req_t   req_r;            // access held for the engine
  csmc_req_t   req_c;            // access wanted in this state
  logic        need_c;           // state wants an access
  csmc_bus_t   bus_r;            // bus outputs
  logic [1:0]  cnt_r;            // state within one bus cycle
  logic        slow_r;           // 8-bit, three-state region
  logic        half_r;           // second byte of a split word
  logic [7:0]  hi_r;             // first byte of a split read
  logic        done_r;           // access finished strobe
  logic [15:0] rdata_r;          // access read data
  logic        take_irq;         // unmasked interrupt pending
  logic        fire;             // instruction accepted
  logic        apb_setup;        // apb setup phase

  // address region for the latched mode and ram enable
  function automatic csmc_region_t region(input logic [15:0] a, input logic [1:0] m,
                                          input logic ram_enable_bit);
    if (a >= REG_BASE)
      region = rg_regs;
    else if (a >= RAM_BASE && a <= RAM_END)
      region = (ram_enable_bit || m == MODE_SINGLE) ? rg_onchip : rg_ext;
    else if (a <= ROM_END)
      region = (m == MODE_EXP_NOROM) ? rg_ext : rg_onchip;
    else
      region = (m == MODE_SINGLE) ? rg_regs : rg_ext;
  endfunction

  assign take_irq  = irq_req && !ccr_r[CCR_I_BIT];
  assign ins_ready = (state_r == st_exec) && !take_irq && hs2;
  assign fire      = ins_valid && ins_ready;
  assign apb_setup = psel && !penable;

  // pin synchronisers, no reset so they track pins during reset
  always_ff @(posedge clk)
  begin
    hs1 <= hw_standby_pin_n;
    hs2 <= hs1;
    md1 <= {mode_pin_high, mode_pin_low};
    md2 <= md1;
  end

  // mode capture on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_r    <= MODE_SINGLE;
      mode_ok_r <= 1'b0;
    end
    else if (!hs2)
      mode_ok_r <= 1'b0;          // standby exit re-latches like reset
    else if (!mode_ok_r)
    begin
      mode_r    <= md2;
      mode_ok_r <= 1'b1;
    end
  end

  // system_control; standby pin also reinitialises it
  always_ff @(posedge clk)
  begin
    if (srst || !hs2)
      sysctl_r <= SYSCTL_RST;
    else if (psel && penable && pwrite && pstrb[0] && paddr == SYSCTL_ADDR)
      sysctl_r <= (sysctl_r & ~SYSCTL_WMASK) | (pwdata[7:0] & SYSCTL_WMASK);
  end

  // mode status follows the pins until the mode is latched, then only a read latches it
  always_ff @(posedge clk)
  begin
    if (srst)
      mds_r <= 2'h0;
    else if (!mode_ok_r || (apb_setup && !pwrite && paddr == MODEIND_ADDR))
      mds_r <= md2;
  end

  // apb read data and error taken at setup, zero wait states;
  // served in every core state so that no setup is ever lost
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end
    else if (apb_setup)
    begin
      err_r    <= !(paddr == SYSCTL_ADDR || paddr == MODEIND_ADDR);
      prdata_r <= 32'h0000_0000;
      if (paddr == SYSCTL_ADDR)
        prdata_r <= {24'h00_0000, sysctl_r};
      else if (paddr == MODEIND_ADDR && !pwrite)
        prdata_r <= {24'h00_0000, MODEIND_RSV | {6'h00, md2}};
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_r;

  // access wanted by each state
  always_comb
  begin
    need_c = 1'b1;
    req_c  = '0;
    unique case (state_r)
      st_reset:      begin need_c = mode_ok_r; req_c = '{RST_VEC, 16'h0000, 1'b1, 1'b0}; end
      st_push_pc:    req_c = '{sp_r - STK_STEP, pc_r, 1'b1, 1'b1};
      st_push_flags: req_c = '{sp_r - STK_STEP, {ccr_r, ccr_r}, 1'b1, 1'b1};
      st_vector:     req_c = '{vec_r, 16'h0000, 1'b1, 1'b0};
      st_pop_flags,
      st_pop_pc:     req_c = '{sp_r, 16'h0000, 1'b1, 1'b0};
      st_mv_read:    req_c = '{mv_r.src, 16'h0000, 1'b0, 1'b0};
      st_mv_write:   req_c = '{mv_r.dst, {8'h00, mv_byte_r}, 1'b0, 1'b1};
      default:       need_c = 1'b0;
    endcase
  end

  // issue one access per state visit
  always_ff @(posedge clk)
  begin
    if (srst || !hs2)
    begin
      go_r     <= 1'b0;
      issued_r <= 1'b0;
      req_r    <= '0;
    end
    else
    begin
      go_r <= 1'b0;
      if (need_c && !issued_r)
      begin
        go_r     <= 1'b1;
        issued_r <= 1'b1;
        req_r    <= req_c;
      end
      else if (done_r)
        issued_r <= 1'b0;
    end
  end

  // bus engine, one state per clock edge
  always_ff @(posedge clk)
  begin
    if (srst || !hs2)
    begin
      bus_r   <= '0;
      cnt_r   <= 2'h0;
      slow_r  <= 1'b0;
      half_r  <= 1'b0;
      hi_r    <= 8'h00;
      done_r  <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      done_r <= 1'b0;
      if (go_r && !bus_r.active)
      begin
        bus_r.active <= 1'b1;
        bus_r.tstate <= 2'h1;
        bus_r.addr   <= req_r.addr;
        bus_r.we     <= req_r.we;
        bus_r.word   <= req_r.word;
        bus_r.ext    <= region(req_r.addr, mode_r, sysctl_r[RAM_ENABLE_BIT_BIT]) == rg_ext;
        slow_r       <= region(req_r.addr, mode_r, sysctl_r[RAM_ENABLE_BIT_BIT]) != rg_onchip;
        // slow word writes send the high byte first
        if (region(req_r.addr, mode_r, sysctl_r[RAM_ENABLE_BIT_BIT]) != rg_onchip && req_r.word)
          bus_r.wdata <= {8'h00, req_r.wdata[15:8]};
        else
          bus_r.wdata <= req_r.wdata;
        cnt_r  <= 2'h0;
        half_r <= 1'b0;
      end
      else if (bus_r.active)
      begin
        if (cnt_r == (slow_r ? SLOW_LAST : FAST_LAST))
        begin
          if (slow_r && bus_r.word && !half_r)
          begin
            half_r       <= 1'b1;
            cnt_r        <= 2'h0;
            bus_r.tstate <= 2'h1;
            bus_r.addr   <= bus_r.addr + PTR_STEP;
            bus_r.wdata  <= {8'h00, req_r.wdata[7:0]};
            hi_r         <= bus_rdata[7:0];
          end
          else
          begin
            bus_r.active <= 1'b0;
            bus_r.tstate <= 2'h0;
            done_r       <= 1'b1;
            if (!slow_r)
              rdata_r <= bus_rdata;
            else if (bus_r.word)
              rdata_r <= {hi_r, bus_rdata[7:0]};
            else
              rdata_r <= {8'h00, bus_rdata[7:0]};
          end
        end
        else
        begin
          cnt_r        <= cnt_r + 2'h1;
          bus_r.tstate <= bus_r.tstate + 2'h1;
        end
      end
    end
  end

  // cpu core sequence
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r    <= st_reset;
      ccr_r      <= CCR_RST;
      pc_r       <= PC_RST;
      sp_r       <= SP_RST;
      vec_r      <= RST_VEC;
      mv_r       <= '0;
      mv_byte_r  <= 8'h00;
      st_valid_r <= 1'b0;
      st_data_r  <= 8'h00;
      irq_ack_r  <= 1'b0;
    end
    else
    begin
      st_valid_r <= 1'b0;
      irq_ack_r  <= 1'b0;
      if (!hs2)
        state_r <= st_hw_standby;
      else
        unique case (state_r)
          st_hw_standby: state_r <= st_reset;
          st_reset:
            if (done_r)
            begin
              pc_r             <= rdata_r;
              ccr_r[CCR_I_BIT] <= 1'b1;
              state_r          <= st_exec;
            end
          st_exec:
            if (take_irq)
            begin
              vec_r     <= irq_vec;
              irq_ack_r <= 1'b1;
              state_r   <= st_push_pc;
            end
            else if (fire)
            begin
              pc_r <= pc_r + PC_STEP;
              unique case (ins.op)
                op_nop: ;
                op_sleep:
                  state_r <= sysctl_r[STANDBY_SELECT_BIT_BIT] ? st_sw_standby : st_sleep;
                op_return_from_exception:
                begin
                  pc_r    <= pc_r;
                  state_r <= st_pop_flags;
                end
                op_load_flags_imm: ccr_r <= ins.imm;
                op_load_flags_reg: ccr_r <= ins.gpr;
                op_store_flags:
                begin
                  st_valid_r <= 1'b1;
                  st_data_r  <= ccr_r;
                end
                op_flags_and_imm: ccr_r <= ccr_r & ins.imm;
                op_flags_or_imm:  ccr_r <= ccr_r | ins.imm;
                op_flags_xor_imm: ccr_r <= ccr_r ^ ins.imm;
                op_block_move:
                begin
                  mv_r <= '{ins.cnt, ins.src, ins.dst};
                  if (ins.cnt == 8'h00)
                    pc_r <= pc_r + PC_STEP_MV;
                  else
                  begin
                    pc_r    <= pc_r;
                    state_r <= st_mv_read;
                  end
                end
                default: ;
              endcase
            end
          st_push_pc:
            if (done_r)
            begin
              sp_r    <= sp_r - STK_STEP;
              state_r <= st_push_flags;
            end
          st_push_flags:
            if (done_r)
            begin
              sp_r    <= sp_r - STK_STEP;
              state_r <= st_vector;
            end
          st_vector:
            if (done_r)
            begin
              pc_r             <= rdata_r;
              ccr_r[CCR_I_BIT] <= 1'b1;
              state_r          <= st_exec;
            end
          st_pop_flags:
            if (done_r)
            begin
              ccr_r   <= rdata_r[15:8];
              sp_r    <= sp_r + STK_STEP;
              state_r <= st_pop_pc;
            end
          st_pop_pc:
            if (done_r)
            begin
              pc_r    <= rdata_r;
              sp_r    <= sp_r + STK_STEP;
              state_r <= st_exec;
            end
          st_mv_read:
            if (done_r)
            begin
              mv_byte_r <= rdata_r[7:0];
              state_r   <= st_mv_write;
            end
          st_mv_write:
            if (done_r)
            begin
              // pointer wrap past the top is left to software
              mv_r.src <= mv_r.src + PTR_STEP;
              mv_r.dst <= mv_r.dst + PTR_STEP;
              mv_r.cnt <= mv_r.cnt - CNT_STEP;
              if (mv_r.cnt == CNT_STEP)
              begin
                pc_r    <= pc_r + PC_STEP_MV;
                state_r <= st_exec;
              end
              else
                state_r <= st_mv_read;
            end
          st_sleep, st_sw_standby:
            if (take_irq)
            begin
              vec_r     <= irq_vec;
              irq_ack_r <= 1'b1;
              state_r   <= st_push_pc;
            end
          default: state_r <= st_reset;
        endcase
    end
  end

  // power-down outputs, one cycle behind the state
  always_ff @(posedge clk)
  begin
    if (srst)
      pwr_r <= '0;
    else
      unique case (state_r)
        st_sleep:      pwr_r <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        st_sw_standby: pwr_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        st_hw_standby: pwr_r <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        default:       pwr_r <= '0;
      endcase
  end

  assign flags         = ccr_r;
  assign pc            = pc_r;
  assign sp            = sp_r;
  assign store_valid   = st_valid_r;
  assign store_data    = st_data_r;
  assign irq_ack       = irq_ack_r;
  assign mv            = mv_r;
  assign bus           = bus_r;
  assign pwr           = pwr_r;
  assign mode          = mode_r;
  assign mode_expanded = mode_r != MODE_SINGLE;
  assign rom_enable    = mode_r != MODE_EXP_NOROM;
  assign ports_gpio    = mode_r == MODE_SINGLE;

  // checking helper: cycles the bus stayed active
  logic [2:0] len_r;
  always_ff @(posedge clk)
    len_r <= (srst || !bus_r.active) ? 3'h0 : len_r + 3'h1;

  a_fast_len: assert property (@(posedge clk) disable iff (srst)
    done_r && !slow_r |-> len_r == FAST_LEN) else $error("fast cycle length wrong");
  a_slow_len: assert property (@(posedge clk) disable iff (srst)
    done_r && slow_r && !bus_r.word |-> len_r == SLOW_LEN) else $error("slow length wrong");
  a_split_len: assert property (@(posedge clk) disable iff (srst)
    done_r && slow_r && bus_r.word |-> len_r == SPLIT_LEN) else $error("split length wrong");
  a_load_flags: assert property (@(posedge clk) disable iff (srst)
    fire && hs2 && ins.op == op_load_flags_imm |=> ccr_r == $past(ins.imm))
    else $error("flags not loaded");
  a_and_flags: assert property (@(posedge clk) disable iff (srst)
    fire && hs2 && ins.op == op_flags_and_imm |=> ccr_r == ($past(ccr_r) & $past(ins.imm)))
    else $error("flags and wrong");
  a_nop_step: assert property (@(posedge clk) disable iff (srst)
    fire && hs2 && ins.op == op_nop |=> pc_r == $past(pc_r) + PC_STEP && $stable(ccr_r))
    else $error("nop effect wrong");
  a_store_out: assert property (@(posedge clk) disable iff (srst)
    fire && hs2 && ins.op == op_store_flags |=> store_valid && store_data == $past(ccr_r))
    else $error("store flags wrong");
  a_move_zero: assert property (@(posedge clk) disable iff (srst)
    fire && hs2 && ins.op == op_block_move && ins.cnt == 8'h00 |=> state_r == st_exec)
    else $error("empty move not skipped");
  a_mask_set: assert property (@(posedge clk) disable iff (srst)
    state_r == st_vector && done_r && hs2 |=> ccr_r[CCR_I_BIT] && state_r == st_exec)
    else $error("mask not set");
  a_pin_standby: assert property (@(posedge clk) disable iff (srst)
    !hs2 |=> state_r == st_hw_standby ##1 pwr_r.port_off) else $error("standby missed");
  a_mode_status: assert property (@(posedge clk) disable iff (srst)
    apb_setup && !pwrite && paddr == MODEIND_ADDR |=> mds_r == prdata_r[1:0])
    else $error("mode status not latched");

  c_move: cover property (@(posedge clk) state_r == st_mv_write && done_r && mv_r.cnt == CNT_STEP);
  c_wake: cover property (@(posedge clk) state_r == st_sleep ##1 state_r == st_push_pc);
  c_soft: cover property (@(posedge clk) state_r == st_sw_standby);
  c_split: cover property (@(posedge clk) done_r && slow_r && bus_r.word);

endmodule
`default_nettype wire

//--- design/csmc_pkg.sv
package csmc_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] SYSCTL_IDX   = 16'hFFC4;
  localparam logic [15:0] MODEIND_IDX  = 16'hFFC5;
  localparam logic [17:0] SYSCTL_ADDR  = {SYSCTL_IDX, 2'b00};
  localparam logic [17:0] MODEIND_ADDR = {MODEIND_IDX, 2'b00};

  // system_control layout
  localparam logic [7:0] SYSCTL_RST   = 8'h09;  // xrst and ram enable set
  localparam logic [7:0] SYSCTL_WMASK = 8'hF7;  // bit 3 is read only
  localparam int         STANDBY_SELECT_BIT_BIT     = 7;      // standby_select_bit
  localparam int         RAM_ENABLE_BIT_BIT     = 0;      // ram_enable_bit

  // mode_indication fixed bits around the two mode status bits
  localparam logic [7:0] MODEIND_RSV  = 8'hE4;

  // flags register
  localparam int         CCR_I_BIT    = 7;      // interrupt mask
  localparam logic [7:0] CCR_RST      = 8'h80;

  // operating modes as seen on {mode_pin_high, mode_pin_low}
  localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
  localparam logic [1:0] MODE_EXP_ROM   = 2'h2;
  localparam logic [1:0] MODE_SINGLE    = 2'h3;

  // address map
  localparam logic [15:0] ROM_END  = 16'h7FFF;
  localparam logic [15:0] RAM_BASE = 16'hFB80;
  localparam logic [15:0] RAM_END  = 16'hFF7F;
  localparam logic [15:0] REG_BASE = 16'hFF80;
  localparam logic [15:0] RST_VEC  = 16'h0000;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [15:0] SP_RST   = 16'hFF80;

  // steps
  localparam logic [15:0] PC_STEP    = 16'h0002;
  localparam logic [15:0] PC_STEP_MV = 16'h0004;
  localparam logic [15:0] STK_STEP   = 16'h0002;
  localparam logic [15:0] PTR_STEP   = 16'h0001;
  localparam logic [7:0]  CNT_STEP   = 8'h01;

  // bus cycle: last state index, counted from zero
  localparam logic [1:0] FAST_LAST = 2'h1;     // two states
  localparam logic [1:0] SLOW_LAST = 2'h2;     // three states
  localparam logic [2:0] FAST_LEN  = 3'h2;
  localparam logic [2:0] SLOW_LEN  = 3'h3;
  localparam logic [2:0] SPLIT_LEN = 3'h6;

  typedef enum logic [3:0] {
    op_nop, op_sleep, op_return_from_exception, op_load_flags_imm,
    op_load_flags_reg, op_store_flags, op_flags_and_imm,
    op_flags_or_imm, op_flags_xor_imm, op_block_move
  } csmc_op_t;

  typedef enum logic [3:0] {
    st_reset, st_exec, st_push_pc, st_push_flags, st_vector,
    st_pop_flags, st_pop_pc, st_mv_read, st_mv_write,
    st_sleep, st_sw_standby, st_hw_standby
  } csmc_state_t;

  typedef enum logic [1:0] {rg_onchip, rg_regs, rg_ext} csmc_region_t;

  typedef struct packed {
    csmc_op_t    op;
    logic [7:0]  imm;
    logic [7:0]  gpr;
    logic [7:0]  cnt;
    logic [15:0] src;
    logic [15:0] dst;
  } csmc_ins_t;

  typedef struct packed {
    logic [7:0]  cnt;
    logic [15:0] src;
    logic [15:0] dst;
  } csmc_mv_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        word;
    logic        we;
  } csmc_req_t;

  typedef struct packed {
    logic        active;
    logic [1:0]  tstate;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        word;
    logic        ext;
  } csmc_bus_t;

  typedef struct packed {
    logic cpu_halt;
    logic periph_halt;
    logic periph_init;
    logic port_hold;
    logic port_off;
  } csmc_pwr_t;

endpackage

//--- testbench/csmc_mem.sv
`timescale 1ns/10ps
`default_nettype none
// memory and peripherals on the far side of the bus
module csmc_mem
  import csmc_pkg::*;
(
  input  wire logic                clk,
  input  wire csmc_pkg::csmc_bus_t bus,
  output logic [15:0]              bus_rdata
);
  logic [7:0]  m [0:65535];  // byte store
  logic [15:0] last_r = '0;  // last value driven
  logic [15:0] a1;           // second byte of a word
  logic        slow;         // byte-wide cycle
  assign a1 = bus.addr + 16'h0001;
  assign slow = bus.ext || bus.addr >= REG_BASE;
  // an idle bus shows the inverse, so stale data never passes
  assign bus_rdata = !bus.active ? ~last_r : slow ? {8'h00, m[bus.addr]}
    : bus.word ? {m[bus.addr], m[a1]} : {2{m[bus.addr]}};
  initial
    for (int i = 0; i < 65536; i++)
      m[i] = i[7:0] ^ i[15:8];
  // writes land at the last state only
  always @(posedge clk)
  begin
    if (bus.active)
      last_r <= bus_rdata;
    if (bus.active && bus.we && bus.tstate == (slow ? 2'h3 : 2'h2))
    begin
      m[bus.addr] <= slow || !bus.word ? bus.wdata[7:0] : bus.wdata[15:8];
      if (!slow && bus.word)
        m[a1] <= bus.wdata[7:0];
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_cpu_state_and_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_cpu_state_and_mode_control;
  import csmc_pkg::*;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ins_valid = 0;
  logic        irq_req = 0, hw_standby_pin_n = 1, mode_pin_high = 1, mode_pin_low = 1;
  logic        pready, pslverr, ins_ready, irq_ack, store_valid, er;
  logic        mode_expanded, rom_enable, ports_gpio, ram_ext;
  logic [3:0]  pstrb = 4'hF;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] irq_vec = 16'hFC10, pc, sp, bus_rdata, p;
  logic [7:0]  flags, store_data;
  logic [1:0]  mode;
  csmc_ins_t   ins = '0;
  csmc_mv_t    mv;
  csmc_bus_t   bus;
  csmc_pwr_t   pwr;
  int          n_mismatch = 0, samples_checked = 0;
  // op, operand, flags expected after it
  logic [19:0] rows [7] = '{{op_load_flags_imm, 16'h5A5A}, {op_flags_and_imm, 16'h0F0A},
    {op_flags_or_imm, 16'h303A}, {op_flags_xor_imm, 16'hFFC5}, {op_load_flags_reg, 16'h2121},
    {op_nop, 16'hFF21}, {op_store_flags, 16'hFF21}};
  csmc_top dut (.*);
  csmc_mem mem (.*);
  // where the first on-chip ram byte was fetched from; unknown after standby
  always @(posedge clk)
    if (!hw_standby_pin_n)
      ram_ext <= 1'bx;
    else if (bus.active && bus.addr == RAM_BASE)
      ram_ext <= bus.ext;
  initial forever #20 clk = ~clk;
  initial
  begin
    repeat (20000) @(posedge clk);
    fail();
  end
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task fail;
    n_mismatch++;
    summarize();
  endtask
  // bounded wait for ready (a=0) or interrupt ack (a=1)
  task wt(input bit a);
    for (int k = 0; (a ? irq_ack : ins_ready) !== 1'b1; k++)
    begin
      if (k > 400)
        fail();
      @(posedge clk);
      #1;
    end
  endtask
  task go(input csmc_op_t o, input logic [7:0] i, input logic [7:0] c);
    wt(0);
    @(posedge clk);
    ins_valid <= 1'b1;
    ins <= {o, i, i, c, 16'hFB80, 16'hFF90};
    // hold the request until an edge that sees ready high
    for (int k = 0; k == 0 || ins_ready !== 1'b1; k++)
      if (k > 400)
        fail();
      else
        @(posedge clk);
    ins_valid <= 1'b0;
    #1;
  endtask
  task irq;
    @(posedge clk);
    irq_req <= 1'b1;
    wt(1);
    @(posedge clk);
    irq_req <= 1'b0;
    wt(0);
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (int k = 0; k == 0 || pready !== 1'b1; k++)
      if (k > 50)
        fail();
      else
        @(posedge clk);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    #1;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CK({flags, sp}, {CCR_RST, SP_RST})
    wt(0);
    `CK({pc, mode, ports_gpio}, {16'h0001, MODE_SINGLE, 1'b1})
    apb(0, SYSCTL_ADDR, 0);
    `CK(rd, 32'h09)
    apb(1, SYSCTL_ADDR, 0);
    apb(0, SYSCTL_ADDR, 0);
    `CK(rd, 32'h08)
    apb(0, MODEIND_ADDR, 0);
    `CK(rd, 32'hE7)
    apb(0, 18'h0, 32'hFF);
    `CK({er, rd}, 33'h100000000)
    p = pc;
    foreach (rows[j])
    begin
      go(csmc_op_t'(rows[j][19:16]), rows[j][15:8], 8'h00);
      p = p + PC_STEP;
      `CK({flags, pc}, {rows[j][7:0], p})
    end
    `CK({store_valid, store_data}, 9'h121)
    go(op_block_move, 8'h00, 8'h03);
    wt(0);
    `CK({mv, pc}, {8'h00, 16'hFB83, 16'hFF93, p + PC_STEP_MV})
    `CK({mem.m[16'hFF90], mem.m[16'hFF92]}, 16'h7B79)
    go(op_block_move, 8'h00, 8'h00);
    p = p + 16'h0008;
    `CK(pc, p)
    irq();
    `CK({pc, sp, flags}, {16'hECED, 16'hFF7C, 8'hA1})
    go(op_return_from_exception, 8'h00, 8'h00);
    wt(0);
    `CK({pc, sp, flags}, {p, SP_RST, 8'h21})
    for (int s = 0; s < 2; s++)
    begin
      apb(1, SYSCTL_ADDR, {24'h0, s[0], 7'h01});
      go(op_sleep, 8'h00, 8'h00);
      p = p + PC_STEP;
      repeat (4) @(posedge clk);
      #1;
      `CK({ins_ready, pwr, pc}, {2'b01, {3{s[0]}}, 1'b0, p})
      irq();
      `CK({pc, flags}, {16'hECED, 8'hA1})
      go(op_return_from_exception, 8'h00, 8'h00);
    end
    apb(0, SYSCTL_ADDR, 0);
    `CK(rd[7], 1'b1)
    for (int n = 1; n < 4; n++)
    begin
      @(posedge clk);
      {hw_standby_pin_n, mode_pin_high, mode_pin_low} <= {1'b0, n[1:0]};
      repeat (6) @(posedge clk);
      #1;
      `CK({ins_ready, pwr.port_off, pwr.periph_init}, 3'b011)
      @(posedge clk);
      hw_standby_pin_n <= 1'b1;
      #1;
      wt(0);
      `CK({mode, mode_expanded, rom_enable, pc}, {n[1:0], n < 3, n > 1, 16'h0001})
      // ram switched off: expanded modes fetch ram addresses off-chip
      apb(1, SYSCTL_ADDR, 0);
      go(op_block_move, 8'h00, 8'h01);
      wt(0);
      `CK(ram_ext, n < 3)
    end
    summarize();
  end
endmodule
`default_nettype wire
